//--- dv/rbst_top_bench.sv
// Self-checking bench for the RAM self-test engine over its Wishbone registers.
`timescale 1ns/100ps
`default_nettype none
module rbst_top_bench;
    logic        i_clk  = 1'b0;
    logic        i_nrst = 1'b0;
    logic        cyc    = 1'b0;
    logic        stb    = 1'b0;
    logic        we     = 1'b0;
    logic [17:0] adr    = 18'h00000;
    logic [31:0] dat    = 32'h0000_0000;
    logic [3:0]  sel    = 4'hf;
    logic        ack;
    logic [31:0] rdat;
    logic        irq;
    int          err_count  = 0;
    int          num_checks = 0;

    always #5 i_clk = ~i_clk;

    rbst_top i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_ack(ack),
        .o_wb_dat(rdat), .o_master_interrupt_out(irq));

    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d,
                      output logic [31:0] q);
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h000000, d};
        do @(posedge i_clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic report(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk(input logic [15:0] idx, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, idx, 8'h00, q);
        report(q, {24'h000000, e});
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask

    // Starts a test and polls until the engine drops the start bit.
    task automatic run(input logic [7:0] c, input logic [7:0] e);
        logic [31:0] q;
        wr(rbst_pkg::IDX_CTRL, c);
        q = 32'h0000_0008;
        for (int n = 0; n < 40000 && q[3] !== 1'b0; n++) wb(1'b0, rbst_pkg::IDX_CTRL, 8'h00, q);
        chk(rbst_pkg::IDX_CTRL, e);
    endtask

    task automatic chk_irq(input logic e);
        @(posedge i_clk);
        #1 report({31'h0, irq}, {31'h0, e});
    endtask

    task automatic print_verdict;
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (150000) @(posedge i_clk);
        err_count++;
        print_verdict;
    end

    initial begin
        repeat (12) @(posedge i_clk);
        i_nrst <= 1'b1;
        chk(rbst_pkg::IDX_CTRL, 8'h00);
        chk(rbst_pkg::IDX_FAIL_LO, 8'h00);
        chk(rbst_pkg::IDX_FAIL_HI, 8'h00);
        chk(16'h8050, 8'h00);
        wr(rbst_pkg::IDX_CTRL, 8'h28);
        chk(rbst_pkg::IDX_CTRL, 8'h00);
        wr(rbst_pkg::IDX_MODE, 8'h04);
        wr(rbst_pkg::IDX_CTRL, 8'h0b);
        chk(rbst_pkg::IDX_CTRL, 8'h00);
        wr(rbst_pkg::IDX_CTRL, 8'h78);
        chk(rbst_pkg::IDX_CTRL, 8'h70);
        run(8'h28, 8'h21);
        run(8'h38, 8'h31);
        run(8'h58, 8'h52);
        chk(rbst_pkg::IDX_FAIL_LO, 8'h00);
        chk(rbst_pkg::IDX_PEND, 8'h10);
        chk_irq(1'b1);
        wr(rbst_pkg::IDX_PEND, 8'h10);
        chk_irq(1'b0);
        run(8'hc8, 8'hc2);
        chk(rbst_pkg::IDX_FAIL_LO, 8'hfc);
        chk(rbst_pkg::IDX_FAIL_HI, 8'h7f);
        run(8'h98, 8'h92);
        chk(rbst_pkg::IDX_FAIL_LO, 8'h00);
        chk(rbst_pkg::IDX_FAIL_HI, 8'h00);
        run(8'h68, 8'h61);
        run(8'h38, 8'h32);
        print_verdict;
    end
endmodule
`default_nettype wire

//--- hw/rbst_pattern.sv
// Write and expected data for each phase and step of the self-test.
`timescale 1ns/100ps
`default_nettype none
module rbst_pattern (
    input  wire rbst_pkg::rbst_phase_t         i_phase,
    input  wire logic [3:0]                    i_sub,
    input  wire logic [rbst_pkg::WORD_AW-1:0]  i_addr,
    output logic      [31:0]                   o_wdata,
    output logic      [31:0]                   o_expect
);
    function automatic logic [7:0] march_byte(input logic [3:0] sub, input logic [7:0] base);
        logic [7:0] b;
        b = base;
        unique case (sub)
            4'h1:    b = 8'h55;
            4'h2:    b = 8'haa;
            4'h3:    b = 8'h33;
            4'h4:    b = 8'hcc;
            4'h5:    b = 8'h0f;
            4'h6:    b = 8'hf0;
            4'h7:    b = 8'h00;
            4'h8:    b = 8'hff;
            default: b = base;
        endcase
        return b;
    endfunction

    // Incrementing bytes: each lane holds the low eight bits of its byte address.
    wire [7:0]  inc_base = {i_addr[5:0], 2'b00};
    wire [31:0] inc_word = {inc_base + 8'h03, inc_base + 8'h02, inc_base + 8'h01, inc_base};
    wire [7:0]  m0_byte  = march_byte(i_sub, rbst_pkg::BYTE_ZERO);
    wire [7:0]  mf_byte  = march_byte(i_sub, rbst_pkg::BYTE_ONES);

    always_comb begin
        o_wdata = rbst_pkg::DAT_RESET;
        unique case (i_phase)
            rbst_pkg::PH_FILL0,
            rbst_pkg::PH_VER0:   o_wdata = {4{rbst_pkg::BYTE_ZERO}};
            rbst_pkg::PH_FILLF,
            rbst_pkg::PH_VERF:   o_wdata = {4{rbst_pkg::BYTE_ONES}};
            rbst_pkg::PH_MARCH0: o_wdata = {4{m0_byte}};
            rbst_pkg::PH_MARCHF: o_wdata = {4{mf_byte}};
            rbst_pkg::PH_INC,
            rbst_pkg::PH_VINC:   o_wdata = inc_word;
            rbst_pkg::PH_VNINC:  o_wdata = ~inc_word;
            default:             o_wdata = rbst_pkg::DAT_RESET;
        endcase
        o_expect = o_wdata;
    end
endmodule
`default_nettype wire

//--- hw/rbst_pkg.sv
// Shared constants and types for the RAM self-test block.
package rbst_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] IDX_MODE    = 16'h8001;
    localparam logic [15:0] IDX_PEND    = 16'h800a;
    localparam logic [15:0] IDX_CTRL    = 16'h8070;
    localparam logic [15:0] IDX_FAIL_LO = 16'h8071;
    localparam logic [15:0] IDX_FAIL_HI = 16'h8072;

    // Control/status field positions.
    localparam int CTRL_FORCE   = 7;
    localparam int CTRL_SEL_MSB = 6;
    localparam int CTRL_SEL_LSB = 4;
    localparam int CTRL_START   = 3;
    localparam int CTRL_FAIL    = 1;
    localparam int CTRL_PASS    = 0;
    localparam int PEND_FAULT   = 4;
    localparam int MODE_MSB     = 2;

    // Reset values.
    localparam logic [2:0]  MODE_RESET  = 3'h0;
    localparam logic [2:0]  SEL_RESET   = 3'h0;
    localparam logic [15:0] FADDR_RESET = 16'h0000;
    localparam logic [31:0] DAT_RESET   = 32'h0000_0000;

    // Operating mode in which the self-test may be programmed.
    localparam logic [2:0] MODE_SELFTEST = 3'h4;

    // Test select codes.
    localparam logic [2:0] SEL_IDLE0   = 3'h0;
    localparam logic [2:0] SEL_PATTERN = 3'h1;
    localparam logic [2:0] SEL_FILL0   = 3'h2;
    localparam logic [2:0] SEL_VER0    = 3'h3;
    localparam logic [2:0] SEL_FILLF   = 3'h4;
    localparam logic [2:0] SEL_VERF    = 3'h5;
    localparam logic [2:0] SEL_INCDEC  = 3'h6;
    localparam logic [2:0] SEL_IDLE7   = 3'h7;

    // RAM geometry: 32K bytes seen as 8K words of four bytes.
    localparam int          RAM_WORDS = 8192;
    localparam int          WORD_AW   = 13;
    localparam logic [12:0] WORD_LAST = 13'h1fff;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hff;

    // Steps inside one march location: verify base, eight patterns, restore.
    localparam logic [3:0] SUB_BASE     = 4'h0;
    localparam logic [3:0] SUB_LAST_PAT = 4'h8;
    localparam logic [3:0] SUB_RESTORE  = 4'h9;

    typedef enum logic [3:0] {
        PH_FILL0  = 4'b0000,
        PH_MARCH0 = 4'b0001,
        PH_FILLF  = 4'b0011,
        PH_MARCHF = 4'b0010,
        PH_INC    = 4'b0110,
        PH_VINC   = 4'b0111,
        PH_COMPL  = 4'b0101,
        PH_VNINC  = 4'b0100,
        PH_VER0   = 4'b1100,
        PH_VERF   = 4'b1101,
        PH_DONE   = 4'b1111
    } rbst_phase_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WR   = 2'b01,
        ST_RD   = 2'b11,
        ST_CMP  = 2'b10
    } rbst_state_t;

endpackage

//--- hw/rbst_ram.sv
// Self-test view of the 32K x 8 RAM, four bytes per word.
`timescale 1ns/100ps
`default_nettype none
module rbst_ram (
    input  wire logic                        i_clk,
    input  wire logic                        i_we,
    input  wire logic                        i_re,
    input  wire logic [rbst_pkg::WORD_AW-1:0] i_addr,
    input  wire logic [31:0]                 i_wdata,
    output logic      [31:0]                 o_rdata
);
    logic [31:0] mem [rbst_pkg::RAM_WORDS];

    // Read data appears the cycle after the read strobe.
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        if (i_re) begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule
`default_nettype wire

//--- hw/rbst_top.sv
// RAM built-in self-test engine with its Wishbone register file.
// Function
// - Codes 001, 010, 100 and 110 overwrite the RAM contents; codes 011 and 101 only read it.
// - Status bits read-only; others written in mode four.
// - Force bit makes the test report failure.
// - Select field picks test; 000, 111 idle.
// - Code 010 fills zero; 011 verifies zero.
// - Code 100 fills ones; 101 verifies ones.
// - Code 110 runs steps five-eight; 001 full.
// - Pattern test starts by zeroing all RAM.
// - First pass: verify zero, eight patterns, restore zero.
// - Then fill every location with ones.
// - Second pass: verify ones, patterns, restore ones.
// - Write incrementing values, then read back each.
// - Complement every location, then verify complement.
// - Start launches test in mode four; self-clears.
// - Fail set on mismatch, cleared by start.
// - Pass set on clean finish, cleared by start.
// - Four consecutive bytes are checked per access.
// - Failing group address captured in two registers.
// - Failure sets unmaskable fault pending bit.
// - Interrupt output follows any pending bit.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rbst_top (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [17:0] i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic             o_wb_ack,
    output logic      [31:0] o_wb_dat,
    output logic             o_master_interrupt_out
);
    rbst_pkg::rbst_state_t state_reg, state_next;
    rbst_pkg::rbst_phase_t phase_reg, phase_next;
    logic [12:0] addr_reg, addr_next;
    logic [3:0]  sub_reg, sub_next;
    logic [31:0] hold_reg;
    logic        start_reg, pass_reg, fail_reg, force_reg;
    logic [2:0]  sel_reg, mode_reg;
    logic [15:0] fail_addr_reg;
    logic        pend_reg, pend_next;
    logic        ack_reg;
    logic [31:0] dat_reg;
    logic        fail_hit;

    function automatic logic is_write_only(input rbst_pkg::rbst_phase_t ph);
        return (ph == rbst_pkg::PH_FILL0) || (ph == rbst_pkg::PH_FILLF) ||
               (ph == rbst_pkg::PH_INC);
    endfunction

    function automatic logic is_march(input rbst_pkg::rbst_phase_t ph);
        return (ph == rbst_pkg::PH_MARCH0) || (ph == rbst_pkg::PH_MARCHF);
    endfunction

    // First phase of each test; idle codes go straight to done.
    function automatic rbst_pkg::rbst_phase_t first_phase(input logic [2:0] sel);
        rbst_pkg::rbst_phase_t ph;
        ph = rbst_pkg::PH_DONE;
        unique case (sel)
            rbst_pkg::SEL_PATTERN: ph = rbst_pkg::PH_FILL0;
            rbst_pkg::SEL_FILL0:   ph = rbst_pkg::PH_FILL0;
            rbst_pkg::SEL_VER0:    ph = rbst_pkg::PH_VER0;
            rbst_pkg::SEL_FILLF:   ph = rbst_pkg::PH_FILLF;
            rbst_pkg::SEL_VERF:    ph = rbst_pkg::PH_VERF;
            rbst_pkg::SEL_INCDEC:  ph = rbst_pkg::PH_INC;
            default:               ph = rbst_pkg::PH_DONE;
        endcase
        return ph;
    endfunction

    function automatic rbst_pkg::rbst_phase_t next_phase(input rbst_pkg::rbst_phase_t ph,
                                                         input logic [2:0] sel);
        rbst_pkg::rbst_phase_t nx;
        nx = rbst_pkg::PH_DONE;
        unique case (ph)
            rbst_pkg::PH_FILL0:  nx = (sel == rbst_pkg::SEL_PATTERN) ? rbst_pkg::PH_MARCH0
                                                                      : rbst_pkg::PH_DONE;
            rbst_pkg::PH_MARCH0: nx = rbst_pkg::PH_FILLF;
            rbst_pkg::PH_FILLF:  nx = (sel == rbst_pkg::SEL_PATTERN) ? rbst_pkg::PH_MARCHF
                                                                      : rbst_pkg::PH_DONE;
            rbst_pkg::PH_MARCHF: nx = rbst_pkg::PH_INC;
            rbst_pkg::PH_INC:    nx = rbst_pkg::PH_VINC;
            rbst_pkg::PH_VINC:   nx = rbst_pkg::PH_COMPL;
            rbst_pkg::PH_COMPL:  nx = rbst_pkg::PH_VNINC;
            default:             nx = rbst_pkg::PH_DONE;
        endcase
        return nx;
    endfunction

    function automatic rbst_pkg::rbst_state_t entry_state(input rbst_pkg::rbst_phase_t ph);
        if (ph == rbst_pkg::PH_DONE) begin
            return rbst_pkg::ST_IDLE;
        end
        return is_write_only(ph) ? rbst_pkg::ST_WR : rbst_pkg::ST_RD;
    endfunction

    // Bus decode. A request is taken on the edge at which ack rises.
    wire        bus_req   = i_wb_cyc & i_wb_stb & ~ack_reg;
    wire [15:0] bus_idx   = i_wb_adr[17:2];
    wire        wr_lane0  = bus_req & i_wb_we & i_wb_sel[0];
    wire        hit_ctrl  = bus_idx == rbst_pkg::IDX_CTRL;
    wire        hit_mode  = bus_idx == rbst_pkg::IDX_MODE;
    wire        hit_pend  = bus_idx == rbst_pkg::IDX_PEND;
    wire        hit_flo   = bus_idx == rbst_pkg::IDX_FAIL_LO;
    wire        hit_fhi   = bus_idx == rbst_pkg::IDX_FAIL_HI;
    wire        in_stmode = mode_reg == rbst_pkg::MODE_SELFTEST;
    wire        ctrl_wr   = wr_lane0 & hit_ctrl & in_stmode & ~start_reg;
    wire [2:0]  wsel      = i_wb_dat[rbst_pkg::CTRL_SEL_MSB:rbst_pkg::CTRL_SEL_LSB];
    wire        wsel_idle = (wsel == rbst_pkg::SEL_IDLE0) | (wsel == rbst_pkg::SEL_IDLE7);
    wire        launch    = ctrl_wr & i_wb_dat[rbst_pkg::CTRL_START];
    wire        go        = launch & ~wsel_idle;
    wire        pend_clr  = wr_lane0 & hit_pend & i_wb_dat[rbst_pkg::PEND_FAULT];

    // Engine datapath.
    wire [31:0] pat_wdata;
    wire [31:0] pat_expect;
    wire [31:0] ram_rdata;
    wire        in_compl  = phase_reg == rbst_pkg::PH_COMPL;
    wire        ram_we    = state_reg == rbst_pkg::ST_WR;
    wire        ram_re    = state_reg == rbst_pkg::ST_RD;
    wire [31:0] ram_wdata = in_compl ? ~hold_reg : pat_wdata;
    wire        checking  = ~in_compl & ~is_write_only(phase_reg);
    wire        mismatch  = (ram_rdata != pat_expect) | force_reg;
    wire        last_addr = addr_reg == rbst_pkg::WORD_LAST;
    wire        is_mph    = is_march(phase_reg);
    wire        end_phase = next_phase(phase_reg, sel_reg) == rbst_pkg::PH_DONE;

    rbst_pattern u_pattern (
        .i_phase  (phase_reg),
        .i_sub    (sub_reg),
        .i_addr   (addr_reg),
        .o_wdata  (pat_wdata),
        .o_expect (pat_expect)
    );

    rbst_ram u_ram (
        .i_clk   (i_clk),
        .i_we    (ram_we),
        .i_re    (ram_re),
        .i_addr  (addr_reg),
        .i_wdata (ram_wdata),
        .o_rdata (ram_rdata)
    );

    // Sequencer: at most one RAM access per cycle, compare in the cycle after each read.
    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        addr_next  = addr_reg;
        sub_next   = sub_reg;
        fail_hit   = 1'b0;
        unique case (state_reg)
            rbst_pkg::ST_IDLE: begin
                if (go) begin
                    phase_next = first_phase(wsel);
                    state_next = entry_state(first_phase(wsel));
                    addr_next  = '0;
                    sub_next   = rbst_pkg::SUB_BASE;
                end
            end
            rbst_pkg::ST_WR: begin
                if (is_mph && (sub_reg != rbst_pkg::SUB_RESTORE)) begin
                    state_next = rbst_pkg::ST_RD;
                end else begin
                    sub_next = rbst_pkg::SUB_BASE;
                    if (last_addr) begin
                        phase_next = next_phase(phase_reg, sel_reg);
                        state_next = entry_state(next_phase(phase_reg, sel_reg));
                        addr_next  = '0;
                    end else begin
                        addr_next  = addr_reg + 13'h0001;
                        state_next = entry_state(phase_reg);
                    end
                end
            end
            rbst_pkg::ST_RD: begin
                state_next = rbst_pkg::ST_CMP;
            end
            rbst_pkg::ST_CMP: begin
                if (checking && mismatch) begin
                    fail_hit   = 1'b1;
                    state_next = rbst_pkg::ST_IDLE;
                end else if (is_mph) begin
                    sub_next   = (sub_reg == rbst_pkg::SUB_LAST_PAT) ? rbst_pkg::SUB_RESTORE
                                                                      : sub_reg + 4'h1;
                    state_next = rbst_pkg::ST_WR;
                end else if (in_compl) begin
                    state_next = rbst_pkg::ST_WR;
                end else if (last_addr) begin
                    phase_next = next_phase(phase_reg, sel_reg);
                    state_next = entry_state(next_phase(phase_reg, sel_reg));
                    addr_next  = '0;
                end else begin
                    addr_next  = addr_reg + 13'h0001;
                    state_next = rbst_pkg::ST_RD;
                end
            end
            default: state_next = rbst_pkg::ST_IDLE;
        endcase
    end

    wire done_ok  = (state_reg != rbst_pkg::ST_IDLE) & (state_next == rbst_pkg::ST_IDLE) &
                    ~fail_hit;
    wire fail_set = fail_hit | (done_ok & force_reg);
    assign pend_next = fail_set | (pend_reg & ~pend_clr);

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= rbst_pkg::ST_IDLE;
            phase_reg <= rbst_pkg::PH_DONE;
            addr_reg  <= '0;
            sub_reg   <= rbst_pkg::SUB_BASE;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            addr_reg  <= addr_next;
            sub_reg   <= sub_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            hold_reg <= rbst_pkg::DAT_RESET;
        end else if (state_reg == rbst_pkg::ST_CMP) begin
            hold_reg <= ram_rdata;
        end
    end

    // Control and status flags.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            start_reg <= 1'b0;
            force_reg <= 1'b0;
            sel_reg   <= rbst_pkg::SEL_RESET;
            pass_reg  <= 1'b0;
            fail_reg  <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                force_reg <= i_wb_dat[rbst_pkg::CTRL_FORCE];
                sel_reg   <= wsel;
            end
            if (go) begin
                start_reg <= 1'b1;
                pass_reg  <= 1'b0;
                fail_reg  <= 1'b0;
            end else begin
                if (fail_hit || done_ok) begin
                    start_reg <= 1'b0;
                end
                if (fail_set) begin
                    fail_reg <= 1'b1;
                end
                if (done_ok && !force_reg) begin
                    pass_reg <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fail_addr_reg <= rbst_pkg::FADDR_RESET;
        end else if (fail_set) begin
            fail_addr_reg <= {1'b0, addr_reg, 2'b00};
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_reg <= rbst_pkg::MODE_RESET;
            pend_reg <= 1'b0;
            o_master_interrupt_out <= 1'b0;
        end else begin
            if (wr_lane0 && hit_mode) begin
                mode_reg <= i_wb_dat[rbst_pkg::MODE_MSB:0];
            end
            pend_reg <= pend_next;
            o_master_interrupt_out <= pend_next;
        end
    end

    // Read mux; unmapped words read as zero and ignore writes.
    wire [7:0] ctrl_rd = {force_reg, sel_reg, start_reg, 1'b0, fail_reg, pass_reg};
    wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                         hit_mode ? {5'h00, mode_reg} :
                         hit_pend ? {3'h0, pend_reg, 4'h0} :
                         hit_flo  ? fail_addr_reg[7:0] :
                         hit_fhi  ? fail_addr_reg[15:8] : 8'h00;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_reg <= 1'b0;
            dat_reg <= rbst_pkg::DAT_RESET;
        end else begin
            ack_reg <= bus_req;
            dat_reg <= (bus_req && !i_wb_we) ? {24'h000000, rd_byte} : rbst_pkg::DAT_RESET;
        end
    end

    assign o_wb_ack = ack_reg;
    assign o_wb_dat = dat_reg;

    // Checks.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_rd_then_cmp;
        (state_reg == rbst_pkg::ST_RD) ##1 (state_reg == rbst_pkg::ST_CMP);
    endsequence

    a_start_mode_gate: assert property (wr_lane0 && hit_ctrl && !in_stmode && !start_reg
        |=> !start_reg) else $error("start set outside self-test mode");
    a_flags_exclusive: assert property (!(pass_reg && fail_reg))
        else $error("pass and fail both set");
    a_start_clears: assert property ($rose(start_reg) |-> !pass_reg && !fail_reg)
        else $error("flags not cleared on start");
    a_idle_code_noop: assert property (launch && wsel_idle |=> !start_reg && !ram_we
        ##1 !ram_we) else $error("idle select caused activity");
    a_fail_stops: assert property ($rose(fail_reg) |-> !start_reg &&
        state_reg == rbst_pkg::ST_IDLE) else $error("test continued after fail");
    a_fault_pending: assert property ($rose(fail_reg) |-> pend_reg)
        else $error("fault pending not set");
    a_master_interrupt_out_follows: assert property (pend_reg |-> o_master_interrupt_out)
        else $error("interrupt output low while pending");
    a_force_no_pass: assert property (force_reg |=> !$rose(pass_reg))
        else $error("pass reported while forced");
    a_fill_zero: assert property (ram_we && phase_reg == rbst_pkg::PH_FILL0 |->
        ram_wdata == 32'h0000_0000) else $error("zero fill wrote nonzero");
    a_march_step: assert property (ram_we && is_mph && sub_reg != rbst_pkg::SUB_RESTORE
        |=> s_rd_then_cmp) else $error("march write not read back");
    a_compl_data: assert property (ram_we && in_compl |-> ram_wdata == ~hold_reg)
        else $error("complement write wrong");
    a_fail_address: assert property ($rose(fail_reg) |-> fail_addr_reg[1:0] == 2'b00 &&
        fail_addr_reg[14:2] == $past(addr_reg)) else $error("fail address wrong");
    a_done_clears: assert property (start_reg && state_reg != rbst_pkg::ST_IDLE ##1
        state_reg == rbst_pkg::ST_IDLE |-> !start_reg)
        else $error("start not cleared at end");
endmodule
`default_nettype wire
